// >>> verilog/blepsc_pkg.sv
// package: power states, timing constants and carrier structs for the power sequencer
package blepsc_pkg;

	typedef enum logic [1:0] {
		BLEPSC_DORMANT,
		BLEPSC_HIBERNATE,
		BLEPSC_SLEEP,
		BLEPSC_ACTIVE
	} blepsc_state_type;

	typedef enum logic [2:0] {
		BLEPSC_XTAL_12,
		BLEPSC_XTAL_16,
		BLEPSC_XTAL_24,
		BLEPSC_XTAL_26,
		BLEPSC_XTAL_32,
		BLEPSC_XTAL_40
	} blepsc_xtal_type;

	// clock and timing
	localparam int  CLK_MHZ           = 50;
	localparam int  STRAP_LATCH_MS    = 3;
	localparam int  STRAP_LATCH_CYC   = STRAP_LATCH_MS * 1000 * CLK_MHZ;
	localparam int  RC_CAL_CYC_DEF    = 64;
	localparam int  SYNTH_CAL_CYC_DEF = 16;
	localparam int  IDLE_CYC_DEF      = 32;
	localparam int  SLEEP_HOLD_DEF    = 256;
	localparam int  XTAL_WAKE_CYC_DEF = 8;
	localparam int  DEEP_WAKE_CYC_DEF = 32;
	localparam logic [2:0] XTAL_RESET = 3'h1;

	// reset values of outputs
	localparam logic PORT_SPI_RESET = 1'h0;

	// clock enables seen by the analog side
	typedef struct packed {
		logic rc_on;
		logic xtal_core_on;
		logic xtal_low_current;
		logic cpu_on;
	} blepsc_clk_type;

	// radio event handshake
	typedef struct packed {
		logic tx_req;
		logic rx_req;
	} blepsc_radio_req_type;

	typedef struct packed {
		logic synth_cal_busy;
		logic radio_go;
		logic radio_tx;
	} blepsc_radio_ctl_type;

endpackage

// >>> verilog/blepsc_power_ctrl.sv
// power-state sequencer, strap capture and host signalling for the radio module
`timescale 1ns/1ps
`default_nettype none

module blepsc_power_ctrl #(
	parameter int STRAP_CYC     = blepsc_pkg::STRAP_LATCH_CYC,
	parameter int RC_CAL_CYC    = blepsc_pkg::RC_CAL_CYC_DEF,
	parameter int SYNTH_CAL_CYC = blepsc_pkg::SYNTH_CAL_CYC_DEF,
	parameter int IDLE_CYC      = blepsc_pkg::IDLE_CYC_DEF,
	parameter int SLEEP_HOLD    = blepsc_pkg::SLEEP_HOLD_DEF,
	parameter int XTAL_WAKE     = blepsc_pkg::XTAL_WAKE_CYC_DEF,
	parameter int DEEP_WAKE     = blepsc_pkg::DEEP_WAKE_CYC_DEF
) (
	// clock and resets
	input  wire logic                             clk,
	input  wire logic                             reset,
	input  wire logic                             hard_reset_n,
	// host pins
	input  wire logic                             stay_awake_lock,
	input  wire logic                             port_select_strap,
	output logic                                  host_attention_n,
	output logic                                  port_is_spi,
	output logic                                  strap_done,
	// firmware side
	input  wire logic                             config_done,
	input  wire logic                             host_attn_req,
	input  wire logic                             wake_req,
	input  wire logic                             cmd_valid,
	output logic                                  cmd_accept,
	// radio
	input  wire blepsc_pkg::blepsc_radio_req_type radio_req,
	output blepsc_pkg::blepsc_radio_ctl_type      radio_ctl,
	// fuses and clocks
	input  wire logic                             xtal_fuse_valid,
	input  wire logic [2:0]                       xtal_fuse_sel,
	output blepsc_pkg::blepsc_xtal_type           xtal_freq,
	output blepsc_pkg::blepsc_clk_type            clk_ctl,
	output logic                                  rc_cal_busy,
	output blepsc_pkg::blepsc_state_type          power_state
);
	import blepsc_pkg::*;

	// synchronisers
	logic [1:0] rst_sync_q;
	logic [1:0] lock_sync_q;
	logic       lock_prev_q;
	wire        int_reset = reset | ~rst_sync_q[1];
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], hard_reset_n};
		end
	end
	always_ff @(posedge clk or posedge int_reset) begin
		if (int_reset) begin
			lock_sync_q <= 2'h0;
			lock_prev_q <= 1'h0;
		end else begin
			lock_sync_q <= {lock_sync_q[0], stay_awake_lock};
			lock_prev_q <= lock_sync_q[1];
		end
	end
	wire lock_s    = lock_sync_q[1];
	wire lock_rise = lock_s & ~lock_prev_q;

	function automatic logic [31:0] dec(input logic [31:0] v);
		dec = (v == 32'h0) ? 32'h0 : v - 32'h1;
	endfunction

	// strap capture window after power-on reset
	logic [31:0] strap_cnt_q;
	logic        strap_done_q;
	logic        spi_q;
	wire         strap_end = ~strap_done_q && (strap_cnt_q == 32'(STRAP_CYC - 1));
	// latch strap once, at end of power-on window
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_cnt_q  <= 32'h0;
			strap_done_q <= 1'h0;
			spi_q        <= PORT_SPI_RESET;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 32'h1;
			if (strap_end) begin
				strap_done_q <= 1'h1;
				spi_q        <= port_select_strap;
			end
		end
	end

	// crystal select, fuse overrides 16 MHz default
	logic [2:0] xtal_q;
	wire        fuse_ok = xtal_fuse_valid && (xtal_fuse_sel <= 3'h5);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			xtal_q <= XTAL_RESET;
		end else if (!strap_done_q) begin
			xtal_q <= fuse_ok ? xtal_fuse_sel : XTAL_RESET;
		end
	end

	// power state machine
	blepsc_state_type st_q, st_d;
	logic [31:0]      tmr_q, tmr_d;
	logic             rc_cal_q;
	logic             synth_q;
	logic [31:0]      synth_cnt_q;
	logic             go_q;
	logic             go_tx_q;
	wire              cfg_ok   = config_done & strap_done_q;
	wire              radio_rq = radio_req.tx_req | radio_req.rx_req;
	wire              busy     = rc_cal_q | synth_q | go_q | radio_rq;
	wire              wake_any = wake_req | lock_rise | host_attn_req;

	always_comb begin
		st_d   = st_q;
		tmr_d  = dec(tmr_q);
		case (st_q)
			BLEPSC_ACTIVE: begin
				if (busy || wake_req || lock_s || !cfg_ok || host_attn_req) begin
					tmr_d  = 32'(IDLE_CYC);
				end else if (tmr_q == 32'h0) begin
					st_d  = BLEPSC_SLEEP;
					tmr_d = 32'(SLEEP_HOLD);
				end
			end
			BLEPSC_SLEEP: begin
				if (wake_any) begin
					st_d  = BLEPSC_ACTIVE;
					tmr_d = 32'(IDLE_CYC + XTAL_WAKE);
				end else if (tmr_q == 32'h0) begin
					st_d = BLEPSC_HIBERNATE;
				end
			end
			BLEPSC_HIBERNATE: begin
				if (wake_any) begin
					st_d   = BLEPSC_ACTIVE;
					tmr_d  = 32'(IDLE_CYC + DEEP_WAKE);
				end
			end
			default: begin
				st_d = BLEPSC_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge int_reset) begin
		if (int_reset) begin
			st_q   <= BLEPSC_ACTIVE;
			tmr_q  <= 32'h0;
		end else begin
			st_q   <= st_d;
			tmr_q  <= tmr_d;
		end
	end

	// rc calibration on every active entry
	logic [31:0] rc_cnt_q;
	wire         enter_act = (st_d == BLEPSC_ACTIVE) && (st_q != BLEPSC_ACTIVE);
	always_ff @(posedge clk or posedge int_reset) begin
		if (int_reset) begin
			rc_cal_q <= 1'h1;
			rc_cnt_q <= 32'(RC_CAL_CYC);
		end else if (enter_act) begin
			rc_cal_q <= 1'h1;
			rc_cnt_q <= 32'(RC_CAL_CYC);
		end else if (rc_cal_q) begin
			rc_cnt_q <= dec(rc_cnt_q);
			rc_cal_q <= (rc_cnt_q > 32'h1);
		end
	end

	// synth calibration before each radio event
	wire start_cal = radio_rq && !synth_q && !go_q && (st_q == BLEPSC_ACTIVE);
	always_ff @(posedge clk or posedge int_reset) begin
		if (int_reset) begin
			synth_q     <= 1'h0;
			synth_cnt_q <= 32'h0;
			go_q        <= 1'h0;
			go_tx_q     <= 1'h0;
		end else if (start_cal) begin
			synth_q     <= 1'h1;
			synth_cnt_q <= 32'(SYNTH_CAL_CYC);
			go_tx_q     <= radio_req.tx_req;
		end else if (synth_q) begin
			synth_cnt_q <= dec(synth_cnt_q);
			if (synth_cnt_q <= 32'h1) begin
				synth_q <= 1'h0;
				go_q    <= 1'h1;
			end
		end else begin
			go_q <= 1'h0;
		end
	end

	// outputs straight from flops
	logic           attn_n_q;
	logic           accept_q;
	blepsc_clk_type clk_q;
	always_ff @(posedge clk or posedge int_reset) begin
		if (int_reset) begin
			attn_n_q <= 1'h1;
			accept_q <= 1'h0;
			clk_q    <= '{rc_on: 1'h1, xtal_core_on: 1'h1, xtal_low_current: 1'h0, cpu_on: 1'h1};
		end else begin
			attn_n_q <= ~host_attn_req;
			accept_q <= cmd_valid && (st_d == BLEPSC_ACTIVE) && (st_q == BLEPSC_ACTIVE);
			clk_q.rc_on            <= 1'h1;
			clk_q.xtal_core_on     <= (st_d != BLEPSC_HIBERNATE);
			clk_q.xtal_low_current <= (st_d == BLEPSC_SLEEP);
			clk_q.cpu_on           <= (st_d == BLEPSC_ACTIVE);
		end
	end

	assign host_attention_n = attn_n_q;
	assign port_is_spi      = spi_q;
	assign strap_done       = strap_done_q;
	assign cmd_accept       = accept_q;
	assign radio_ctl        = '{synth_cal_busy: synth_q, radio_go: go_q, radio_tx: go_tx_q};
	assign xtal_freq        = blepsc_xtal_type'(xtal_q);
	assign clk_ctl          = clk_q;
	assign rc_cal_busy      = rc_cal_q;
	assign power_state      = st_q;

	// checks
	// never dormant
	a_no_dormant_state: assert property (@(posedge clk) disable iff (int_reset)
		st_q != BLEPSC_DORMANT) else $error("dormant state selected");
	a_lock_keeps_awake: assert property (@(posedge clk) disable iff (int_reset)
		lock_s && st_q == BLEPSC_ACTIVE |=> st_q == BLEPSC_ACTIVE)
		else $error("left active while lock held");
	a_lock_edge_wakes: assert property (@(posedge clk) disable iff (int_reset)
		lock_rise |=> st_q == BLEPSC_ACTIVE) else $error("lock edge did not wake");
	a_cal_before_radio: assert property (@(posedge clk) disable iff (int_reset)
		$rose(go_q) |-> $past(synth_q)) else $error("radio started without calibration");
	a_cal_length_ok: assert property (@(posedge clk) disable iff (int_reset)
		start_cal && (SYNTH_CAL_CYC == 16) |=> synth_q [*8] ##1 synth_q [*8] ##1 (go_q && !synth_q))
		else $error("calibration length wrong");
	a_accept_only_active: assert property (@(posedge clk) disable iff (int_reset)
		accept_q |-> st_q == BLEPSC_ACTIVE) else $error("command accepted while asleep");
	a_hib_xtal_off: assert property (@(posedge clk) disable iff (int_reset)
		st_q == BLEPSC_HIBERNATE && $past(st_q) == BLEPSC_HIBERNATE |-> !clk_q.xtal_core_on)
		else $error("crystal on in hibernate");
	a_sleep_xtal_low: assert property (@(posedge clk) disable iff (int_reset)
		st_q == BLEPSC_SLEEP |-> clk_q.xtal_core_on && clk_q.xtal_low_current)
		else $error("crystal not low current in sleep");
	a_rc_cal_on_wake: assert property (@(posedge clk) disable iff (int_reset)
		enter_act |=> rc_cal_q) else $error("rc calibration not started");
	a_attn_follows_req: assert property (@(posedge clk) disable iff (int_reset)
		host_attn_req |=> !host_attention_n) else $error("attention not asserted");
	a_strap_stable: assert property (@(posedge clk) disable iff (reset)
		strap_done_q && $past(strap_done_q) |-> $stable(spi_q)) else $error("strap changed");

	c_enter_sleep: cover property (@(posedge clk) disable iff (int_reset)
		st_q == BLEPSC_ACTIVE ##1 st_q == BLEPSC_SLEEP);
	c_enter_hib: cover property (@(posedge clk) disable iff (int_reset)
		st_q == BLEPSC_SLEEP ##1 st_q == BLEPSC_HIBERNATE);
	c_radio_event: cover property (@(posedge clk) disable iff (int_reset) $rose(go_q));
	c_lock_wake: cover property (@(posedge clk) disable iff (int_reset)
		st_q == BLEPSC_HIBERNATE ##1 lock_rise);

endmodule

`default_nettype wire

// >>> testbench/blepsc_host_model.sv
// host-side model: strap, wake lock and hardware reset pins
`timescale 1ns/1ps
`default_nettype none
module blepsc_host_model (
	// commands from bench
	input  wire logic clk,
	input  wire logic strap_spi,
	input  wire logic lock_cmd,
	input  wire logic rst_cmd,
	// pins to device
	output logic      stay_awake_lock,
	output logic      port_select_strap,
	output logic      hard_reset_n
);
	// strap steady from power-on, high for spi
	assign port_select_strap = strap_spi;
	// lock raised while host loads or tests
	always_ff @(posedge clk) stay_awake_lock <= lock_cmd;
	// host pulls reset low, then reconfigures
	always_ff @(posedge clk) hard_reset_n <= ~rst_cmd;
endmodule
`default_nettype wire

// >>> testbench/test_blepsc_power_ctrl.sv
// testbench for the power sequencer
`timescale 1ns/1ps
`default_nettype none
module test_blepsc_power_ctrl;
	import blepsc_pkg::*;
	logic                 clk = 0, reset = 1, strap_spi = 1;
	logic                 lock_cmd = 0, rst_cmd = 0, config_done = 0;
	logic                 host_attn_req = 0, wake_req = 0, cmd_valid = 0;
	logic                 xtal_fuse_valid = 0;
	logic [2:0]           xtal_fuse_sel = 3'h0;
	logic                 cmd_accept, host_attention_n, port_is_spi, strap_done;
	logic                 rc_cal_busy, stay_awake_lock, port_select_strap, hard_reset_n;
	blepsc_radio_req_type radio_req = '0;
	blepsc_radio_ctl_type radio_ctl;
	blepsc_xtal_type      xtal_freq;
	blepsc_clk_type       clk_ctl;
	blepsc_state_type     power_state;
	int                   n_errors = 0, checks = 0;

	always #10 clk = ~clk;

	blepsc_host_model i_blepsc_host_model (.clk(clk), .strap_spi(strap_spi),
		.lock_cmd(lock_cmd), .rst_cmd(rst_cmd), .stay_awake_lock(stay_awake_lock),
		.port_select_strap(port_select_strap), .hard_reset_n(hard_reset_n));

	blepsc_power_ctrl #(.STRAP_CYC(20)) i_blepsc_power_ctrl (.clk(clk), .reset(reset),
		.hard_reset_n(hard_reset_n), .stay_awake_lock(stay_awake_lock),
		.port_select_strap(port_select_strap), .host_attention_n(host_attention_n),
		.port_is_spi(port_is_spi), .strap_done(strap_done), .config_done(config_done),
		.host_attn_req(host_attn_req), .wake_req(wake_req), .cmd_valid(cmd_valid),
		.cmd_accept(cmd_accept), .radio_req(radio_req), .radio_ctl(radio_ctl),
		.xtal_fuse_valid(xtal_fuse_valid), .xtal_fuse_sel(xtal_fuse_sel),
		.xtal_freq(xtal_freq), .clk_ctl(clk_ctl), .rc_cal_busy(rc_cal_busy),
		.power_state(power_state));

	task automatic end_sim();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(string what, logic [4:0] e, logic [4:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %0h got %0h", what, e, g);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// bounded wait for a power state
	task automatic wait_state(blepsc_state_type s, int bound);
		for (int i = 0; i < bound && power_state !== s; i++)
			cyc(1);
		if (power_state !== s) begin
			n_errors++;
			$display("BAD state wait exp %0d got %0d", s, power_state);
			end_sim();
		end
	endtask

	// one command cycle, count accepts seen
	task automatic cmd_try(logic [4:0] exp);
		int n;
		n = 0;
		@(posedge clk) cmd_valid <= 1;
		@(posedge clk) cmd_valid <= 0;
		#1 n += (cmd_accept === 1'b1);
		repeat (2) begin
			cyc(1);
			n += (cmd_accept === 1'b1);
		end
		chk("cmd_accept count", exp, n[4:0]);
	endtask

	task automatic t_boot();
		cyc(25);
		chk("strap_done", 1, strap_done);
		chk("port_is_spi", 1, port_is_spi);
		chk("state", BLEPSC_ACTIVE, power_state);
		chk("attention", 1, host_attention_n);
		chk("xtal", BLEPSC_XTAL_16, xtal_freq);
		cmd_try(1);
	endtask

	task automatic t_radio();
		int n;
		for (int tx = 1; tx >= 0; tx--) begin
			@(posedge clk) radio_req <= tx ? 2'b10 : 2'b01;
			for (n = 0; n < 5 && radio_ctl.synth_cal_busy !== 1; n++)
				cyc(1);
			for (n = 0; n < 40 && radio_ctl.synth_cal_busy === 1; n++) begin
				chk("go in cal", 0, radio_ctl.radio_go);
				cyc(1);
			end
			chk("cal cycles", SYNTH_CAL_CYC_DEF, n[4:0]);
			chk("radio_go", 1, radio_ctl.radio_go);
			chk("radio_tx", tx[0], radio_ctl.radio_tx);
			@(posedge clk) radio_req <= '0;
			cyc(40);
		end
	endtask

	task automatic t_power();
		@(posedge clk) config_done <= 1;
		wait_state(BLEPSC_SLEEP, 400);
		chk("sleep clocks", 4'b1110, clk_ctl);
		cmd_try(0);
		wait_state(BLEPSC_HIBERNATE, 400);
		chk("hibernate clocks", 4'b1000, clk_ctl);
		@(posedge clk) wake_req <= 1;
		wait_state(BLEPSC_ACTIVE, 4);
		chk("rc cal on wake", 1, rc_cal_busy);
		chk("cpu on", 1, clk_ctl.cpu_on);
		@(posedge clk) wake_req <= 0;
		cyc(RC_CAL_CYC_DEF + 4);
		chk("rc cal end", 0, rc_cal_busy);
	endtask

	task automatic t_lock();
		@(posedge clk) lock_cmd <= 1;
		cyc(300);
		chk("held awake", BLEPSC_ACTIVE, power_state);
		@(posedge clk) lock_cmd <= 0;
		wait_state(BLEPSC_SLEEP, 300);
		@(posedge clk) lock_cmd <= 1;
		wait_state(BLEPSC_ACTIVE, 8);
		cyc(200);
		chk("lock wake stays", BLEPSC_ACTIVE, power_state);
		@(posedge clk) lock_cmd <= 0;
	endtask

	task automatic t_attn_hrst();
		wait_state(BLEPSC_SLEEP, 300);
		@(posedge clk) host_attn_req <= 1;
		cyc(3);
		chk("attention low", 0, host_attention_n);
		wait_state(BLEPSC_ACTIVE, 3);
		@(posedge clk) host_attn_req <= 0;
		cyc(3);
		chk("attention idle", 1, host_attention_n);
		wait_state(BLEPSC_SLEEP, 300);
		@(posedge clk) rst_cmd <= 1;
		cyc(6);
		chk("hard reset state", BLEPSC_ACTIVE, power_state);
		chk("hard reset cal", 1, rc_cal_busy);
		@(posedge clk) rst_cmd <= 0;
		cyc(6);
		chk("strap kept", 1, port_is_spi);
		chk("strap done kept", 1, strap_done);
	endtask

	// second power-on reset: open strap and a valid fuse
	task automatic t_por_uart();
		@(posedge clk) begin
			reset           <= 1;
			strap_spi       <= 0;
			xtal_fuse_valid <= 1;
			xtal_fuse_sel   <= 3'h5;
		end
		cyc(3);
		chk("por strap_done", 0, strap_done);
		chk("por port_is_spi", PORT_SPI_RESET, port_is_spi);
		chk("por clocks", 4'b1101, clk_ctl);
		chk("por attention", 1, host_attention_n);
		@(posedge clk) reset <= 0;
		cyc(25);
		chk("uart strap", 0, port_is_spi);
		chk("uart strap_done", 1, strap_done);
		chk("fuse xtal", BLEPSC_XTAL_40, xtal_freq);
		chk("por state", BLEPSC_ACTIVE, power_state);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		reset <= 0;
		t_boot();
		t_radio();
		t_power();
		t_lock();
		t_attn_hrst();
		t_por_uart();
		end_sim();
	end
endmodule
`default_nettype wire
